/* File: hw/serial_dac_load_interface.sv */
// Digital loading interface of a multi-channel 10-bit serial DAC.
// Link side: a shift register clocked by the host's shift clock collects
// 16-bit words; a toggle hands each finished word to the system clock.
// System side: data registers, DAC registers, channel controls and the
// clear and power-down pins, all registered on mclk.
// Assumes the host drives frame sync, serial data and the shift clock, and
// that the shift clock may stop between frames. Strobes and power-down are
// asynchronous pins. One asynchronous reset serves both clock domains.
`timescale 1ns/1ps
module serial_dac_load_interface #(
   parameter int CHANNELS = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic shift_clock,
   input wire logic frame_sync_n,
   input wire logic serial_data_in,
   input wire logic load_outputs_n,
   input wire logic clear_all_n,
   input wire logic power_down_n,
   output logic [CHANNELS-1:0][9:0] dac_code,
   output logic [CHANNELS-1:0][5:0] sub_dac_offset,
   output logic [CHANNELS-1:0] external_reference_select,
   output logic low_power
);

   // Clear target chosen by the latched clear level select
   function automatic logic [9:0] clear_code(input logic low_level);
      clear_code = low_level ? dac_load_pkg::BIAS_DIV16_CODE : dac_load_pkg::BIAS_CODE;
   endfunction : clear_code

   // True when a word of the given kind is meant for the given channel;
   // data and control writes decode the channel the same way
   function automatic logic addressed(input dac_load_pkg::link_word_type w, input int index, input logic control);
      addressed = (w.is_control == control) && (int'(w.channel) == index);
   endfunction : addressed

   // Link domain: bit counter, cleared by frame end because the clock stops then
   logic [3:0] bit_count;
   logic [3:0] next_bit_count;
   logic [15:0] shift_word;
   logic [15:0] next_shift_word;
   dac_load_pkg::link_frame_type held_frame;
   dac_load_pkg::link_frame_type next_held_frame;
   logic word_toggle;
   logic next_word_toggle;
   logic frame_done;

   // Bit counter group: counts falling edges inside a frame and wraps after
   // the last bit, so a frame held low across two words stays aligned
   always_comb begin
      next_bit_count = bit_count;
      if (!frame_sync_n) begin // see RL1
         next_bit_count = 4'(bit_count + 4'h1); // see RL2
      end
   end

   // Word group: shifts MSB first and hands the word over at the sixteenth
   // edge by flipping the toggle that the system clock watches
   always_comb begin
      frame_done = !frame_sync_n && (bit_count == dac_load_pkg::LAST_BIT_INDEX); // see RL2
      next_shift_word = shift_word;
      next_held_frame = held_frame;
      next_word_toggle = word_toggle;
      if (!frame_sync_n) begin // see RL1
         next_shift_word = {shift_word[14:0], serial_data_in}; // see RL3
      end
      // The strobe level is taken with the last bit, with data-bit timing
      if (frame_done) begin
         next_held_frame.word = dac_load_pkg::link_word_type'(next_shift_word);
         next_held_frame.auto_update = !load_outputs_n; // see RL5
         next_word_toggle = !word_toggle;
      end
   end

   // Frame end resets the count asynchronously so a short frame never misaligns the next
   always_ff @(negedge shift_clock or posedge reset or posedge frame_sync_n) begin
      if (reset || frame_sync_n) begin
         bit_count <= dac_load_pkg::COUNT_RESET;
      end else begin
         bit_count <= next_bit_count;
      end
   end

   // Shift and hold registers; held word stays put for a whole frame, long enough to cross
   always_ff @(negedge shift_clock or posedge reset) begin
      if (reset) begin
         shift_word <= dac_load_pkg::WORD_RESET;
         held_frame <= '0;
         word_toggle <= 1'b0;
      end else begin
         shift_word <= next_shift_word;
         held_frame <= next_held_frame;
         word_toggle <= next_word_toggle;
      end
   end

   // System domain state
   logic [2:0] toggle_sync;
   logic [2:0] next_toggle_sync;
   logic [2:0] load_sync;
   logic [2:0] next_load_sync;
   logic [1:0] clear_sync;
   logic [1:0] next_clear_sync;
   logic [1:0] power_sync;
   logic [1:0] next_power_sync;
   logic clear_low_select;
   logic next_clear_low_select;
   logic [CHANNELS-1:0][9:0] data_reg;
   logic [CHANNELS-1:0][9:0] next_data_reg;
   logic [CHANNELS-1:0][9:0] next_dac_code;
   logic [CHANNELS-1:0][5:0] next_sub_dac_offset;
   logic [CHANNELS-1:0] next_external_reference_select;
   logic next_low_power;
   logic word_event;
   logic load_event;
   dac_load_pkg::link_word_type rx_word;
   logic strobe_event;
   logic clear_active;

   // Word toggle synchroniser; the third stage keeps the old level for the
   // change detector. Stage 0 may go metastable, so only stage 1 reads it.
   always_comb begin
      next_toggle_sync = {toggle_sync[1:0], word_toggle};
   end

   // Resets to the toggle's own reset level, so no word is seen at release
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         toggle_sync <= 3'h0;
      end else begin
         toggle_sync <= next_toggle_sync;
      end
   end

   // Load strobe synchroniser; the third stage keeps the old level so the
   // falling edge is found after the pin has settled
   always_comb begin
      next_load_sync = {load_sync[1:0], load_outputs_n};
   end

   // Resets high, the idle level of the pin, so release of reset is no edge
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         load_sync <= 3'h7;
      end else begin
         load_sync <= next_load_sync;
      end
   end

   // Clear pin synchroniser, two stages
   always_comb begin
      next_clear_sync = {clear_sync[0], clear_all_n};
   end

   // Resets to the released level so reset alone never forces the clear code
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         clear_sync <= 2'h3;
      end else begin
         clear_sync <= next_clear_sync;
      end
   end

   // Power-down pin synchroniser, two stages
   always_comb begin
      next_power_sync = {power_sync[0], power_down_n};
   end

   // Resets to the awake level, matching the reset value of low_power
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         power_sync <= 2'h3;
      end else begin
         power_sync <= next_power_sync;
      end
   end

   // Events in the system clock, each one cycle wide, plus the clear level. The held word is read
   // only while word_event is high; it has been stable for several cycles by
   // then and stays so until the next word ends, sixteen shift clocks later.
   always_comb begin
      word_event = toggle_sync[2] ^ toggle_sync[1];
      rx_word = held_frame.word;
      strobe_event = load_sync[2] && !load_sync[1]; // see RL4
      clear_active = !clear_sync[1]; // see RL6
      load_event = strobe_event;
      if (word_event && held_frame.auto_update) begin
         load_event = 1'b1; // see RL5
      end
   end

   // Data register group: a data word writes the addressed channel only.
   // Data registers keep their contents through a clear, so a later load
   // brings back the last codes written.
   always_comb begin
      next_data_reg = data_reg;
      for (int i = 0; i < CHANNELS; i++) begin
         if (word_event && addressed(rx_word, i, 1'b0)) begin
            next_data_reg[i] = rx_word.payload;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         data_reg <= {CHANNELS{dac_load_pkg::CODE_RESET}};
      end else begin
         data_reg <= next_data_reg;
      end
   end

   // Clear level group: any control word sets the level for all channels,
   // whichever channel it addresses
   always_comb begin
      next_clear_low_select = clear_low_select;
      if (word_event && rx_word.is_control) begin
         next_clear_low_select = rx_word.clear_low; // see RL6
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         clear_low_select <= 1'b0;
      end else begin
         clear_low_select <= next_clear_low_select;
      end
   end

   // Reference choice group: a control word sets the reference of its
   // channel; a clear leaves the choice alone
   always_comb begin
      next_external_reference_select = external_reference_select;
      for (int i = 0; i < CHANNELS; i++) begin
         if (word_event && addressed(rx_word, i, 1'b1)) begin
            next_external_reference_select[i] = rx_word.payload[9]; // see RL9
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         external_reference_select <= '0;
      end else begin
         external_reference_select <= next_external_reference_select;
      end
   end

   // Offset sub-DAC group: a control word sets the offset of its channel.
   // A clear wins over a control word in the same cycle.
   always_comb begin
      next_sub_dac_offset = sub_dac_offset;
      for (int i = 0; i < CHANNELS; i++) begin
         if (word_event && addressed(rx_word, i, 1'b1)) begin
            next_sub_dac_offset[i] = rx_word.payload[5:0];
         end
         if (clear_active) begin
            next_sub_dac_offset[i] = dac_load_pkg::OFFSET_RESET; // see RL7
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sub_dac_offset <= {CHANNELS{dac_load_pkg::OFFSET_RESET}};
      end else begin
         sub_dac_offset <= next_sub_dac_offset;
      end
   end

   // DAC register group: all channels update in the same cycle, including a
   // word that lands in that very cycle. Clear is a level and overrides any
   // load while held; a strobe that falls during a clear is lost.
   always_comb begin
      next_dac_code = dac_code;
      if (load_event) begin
         next_dac_code = next_data_reg; // see RL4
      end
      if (clear_active) begin
         for (int i = 0; i < CHANNELS; i++) begin
            next_dac_code[i] = clear_code(next_clear_low_select); // see RL6
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         dac_code <= {CHANNELS{dac_load_pkg::CODE_RESET}};
      end else begin
         dac_code <= next_dac_code;
      end
   end

   // Power group: the flag follows the synchronised pin, so a slow or noisy
   // pin edge never reaches the analog blocks unsynchronised
   always_comb begin
      next_low_power = !power_sync[1]; // see RL8
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         low_power <= 1'b0;
      end else begin
         low_power <= next_low_power;
      end
   end

endmodule : serial_dac_load_interface

/* File: hw/dac_load_pkg.sv */
// Constants and carrier types for the serial DAC loading interface.
// Assumes one system clock (mclk) and a separate shift clock driven by the host.
//
// Overview of operation
// RL1: Shift register runs only while frame_sync_n is low; data ignored otherwise.
// RL2: Each frame carries one 16-bit word on serial_data_in.
// RL3: serial_data_in is sampled on each falling shift_clock edge inside a frame.
// RL4: Falling load_outputs_n copies every data register into its DAC register together.
// RL5: load_outputs_n low at the sixteenth falling edge updates DAC registers automatically.
// RL6: clear_all_n low forces every main DAC to bias or bias/16 code.
// RL7: The same clear also resets every offset sub-DAC to zero.
// RL8: power_down_n low puts the device into low-power mode.
// RL9: A control word selects the external reference per DAC.
// RL10: Host holds frame low for sixteen falling edges, data stable at each.
package dac_load_pkg;
   localparam int WORD_BITS = 16;
   localparam int CODE_BITS = 10;
   localparam int OFFSET_BITS = 6;
   localparam int CHAN_BITS = 3;
   localparam logic [3:0] LAST_BIT_INDEX = 4'hf;
   localparam logic [3:0] COUNT_RESET = 4'h0;
   localparam logic [9:0] BIAS_CODE = 10'h200;
   localparam logic [9:0] BIAS_DIV16_CODE = 10'h020;
   localparam logic [9:0] CODE_RESET = 10'h200;
   localparam logic [5:0] OFFSET_RESET = 6'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // Serial word layout, first bit shifted in is bit 15
   typedef struct packed {
      logic is_control;
      logic [2:0] channel;
      logic clear_low;
      logic spare;
      logic [9:0] payload;
   } link_word_type;

   // Word plus the load strobe level sampled at its last edge
   typedef struct packed {
      link_word_type word;
      logic auto_update;
   } link_frame_type;
endpackage : dac_load_pkg

/* File: tb/serial_dac_load_interface_assertions.sv */
// Checker for the DAC loading interface, watching top ports only.
// Assumes frame sync idles high and no control word arrives during a clear.
`timescale 1ns/1ps
module serial_dac_load_interface_assertions #(
   parameter int CHANNELS = 8
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic shift_clock,
   input wire logic frame_sync_n,
   input wire logic serial_data_in,
   input wire logic load_outputs_n,
   input wire logic clear_all_n,
   input wire logic power_down_n,
   input wire logic [CHANNELS-1:0][9:0] dac_code,
   input wire logic [CHANNELS-1:0][5:0] sub_dac_offset,
   input wire logic [CHANNELS-1:0] external_reference_select,
   input wire logic low_power
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // Pin changes pass a two-stage synchroniser, hence the small window
   pd_enter_a: assert property ($fell(power_down_n) |-> ##[3:4] low_power) else $error("sleep late");
   pd_leave_a: assert property ($rose(power_down_n) |-> ##[3:4] !low_power) else $error("wake late");
   clr_offset_a: assert property (!clear_all_n [*4] |-> sub_dac_offset == '0) else $error("offset kept");
   clr_code_a: assert property (!clear_all_n [*4] |-> dac_code[0] inside
      {dac_load_pkg::BIAS_CODE, dac_load_pkg::BIAS_DIV16_CODE}) else $error("bad clear code");
   clr_same_a: assert property (!clear_all_n [*4] |-> dac_code == {CHANNELS{dac_code[0]}}) else $error("mixed");
   clr_hold_a: assert property (!clear_all_n [*5] |-> $stable(dac_code)) else $error("load in clear");
   // Without a strobe or clear the outputs are double buffered
   code_cause_a: assert property ((load_outputs_n && clear_all_n) [*8] |-> $stable(dac_code))
      else $error("code moved");
   ctl_cause_a: assert property ((frame_sync_n && clear_all_n) [*8] |-> $stable(sub_dac_offset)
      && $stable(external_reference_select)) else $error("control moved");
   cover property ($fell(load_outputs_n));
   cover property ($fell(clear_all_n));
   cover property ($fell(power_down_n));
endmodule : serial_dac_load_interface_assertions

/* File: tb/dac_host_model.sv */
// Host model driving frame sync, serial data and the shift clock.
// Assumes send() is called from one process at a time.
`timescale 1ns/1ps
module dac_host_model (
   output logic shift_clock,
   output logic frame_sync_n,
   output logic serial_data_in
);
   initial begin
      shift_clock = 1'b1;
      frame_sync_n = 1'b1;
      serial_data_in = 1'b0;
   end
   // Clock stands high between frames; data line shows no stale bit outside
   task send(input logic [15:0] w, input int n);
      frame_sync_n = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         serial_data_in = w[i];
         #7.5 shift_clock = 1'b0;
         #7.5 shift_clock = 1'b1;
      end
      #7.5 frame_sync_n = 1'b1;
      serial_data_in = ~serial_data_in;
      #40;
   endtask : send
endmodule : dac_host_model

/* File: tb/serial_dac_load_interface_test.sv */
// Self-checking bench for the DAC loading interface.
// Assumes the host model owns the link; pins change at falling mclk.
`timescale 1ns/1ps
module serial_dac_load_interface_test;
   localparam int CHANNELS = 8;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic load_outputs_n = 1'b1;
   logic clear_all_n = 1'b1;
   logic power_down_n = 1'b1;
   logic shift_clock, frame_sync_n, serial_data_in, low_power;
   logic [CHANNELS-1:0][9:0] dac_code;
   logic [CHANNELS-1:0][5:0] sub_dac_offset;
   logic [CHANNELS-1:0] external_reference_select;
   logic [9:0] data [CHANNELS];
   logic [15:0] r = 16'h0012;
   int error_cnt = 0;
   int checks = 0;
   always #4 mclk = ~mclk;
   dac_host_model host (.shift_clock(shift_clock), .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in));
   serial_dac_load_interface #(.CHANNELS(CHANNELS)) uut (.mclk(mclk), .reset(reset), .shift_clock(shift_clock),
      .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in), .load_outputs_n(load_outputs_n),
      .clear_all_n(clear_all_n), .power_down_n(power_down_n), .dac_code(dac_code), .low_power(low_power),
      .sub_dac_offset(sub_dac_offset), .external_reference_select(external_reference_select));
   // Shift register draws keep the run repeatable
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   task chk(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task chk_flag(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: flag got %b want %b", $time, got, exp);
      end
   endtask : chk_flag
   task chk_offset(input logic [5:0] got, input logic [5:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: offset got %h want %h", $time, got, exp);
      end
   endtask : chk_offset
   // Clear code expected for the level chosen by the last control word
   function automatic logic [9:0] exp_clear(input logic low_level);
      return low_level ? dac_load_pkg::BIAS_DIV16_CODE : dac_load_pkg::BIAS_CODE;
   endfunction : exp_clear
   // Margin over the three to four cycle synchroniser latency
   task wait_out;
      repeat (12) @(negedge mclk);
   endtask : wait_out
   task end_of_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20) @(negedge mclk);
      reset = 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
         r = lfsr(r);
         data[i] = r[9:0];
         host.send({1'b0, 3'(i), 2'b00, data[i]}, 16);
      end
      wait_out;
      chk(dac_code[5], dac_load_pkg::CODE_RESET);
      load_outputs_n = 1'b0;
      wait_out;
      for (int i = 0; i < CHANNELS; i++) chk(dac_code[i], data[i]);
      // Strobe held low: a cut-short frame is dropped, next word updates itself
      host.send(16'hffff, 10);
      host.send({4'h5, 2'b00, 10'h155}, 16);
      wait_out;
      chk(dac_code[5], 10'h155);
      load_outputs_n = 1'b1;
      for (int l = 0; l < 2; l++) begin
         r = lfsr(r);
         host.send({4'ha, 1'(l), 1'b0, 1'b1, 3'b000, r[5:0]}, 16);
         wait_out;
         chk_flag(external_reference_select[2], 1'b1);
         chk_offset(sub_dac_offset[2], r[5:0]);
         clear_all_n = 1'b0;
         wait_out;
         chk(dac_code[7], exp_clear(1'(l)));
         chk_offset(sub_dac_offset[2], dac_load_pkg::OFFSET_RESET);
         clear_all_n = 1'b1;
      end
      power_down_n = 1'b0;
      wait_out;
      chk_flag(low_power, 1'b1);
      power_down_n = 1'b1;
      wait_out;
      chk_flag(low_power, 1'b0);
      end_of_test;
   end
   // Watchdog well past the few microseconds the sequence needs
   initial begin
      #100000;
      error_cnt++;
      end_of_test;
   end
endmodule : serial_dac_load_interface_test
bind serial_dac_load_interface serial_dac_load_interface_assertions #(.CHANNELS(CHANNELS)) chk_i (.mclk(mclk),
   .reset(reset), .shift_clock(shift_clock), .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
   .load_outputs_n(load_outputs_n), .clear_all_n(clear_all_n), .power_down_n(power_down_n), .dac_code(dac_code),
   .sub_dac_offset(sub_dac_offset), .external_reference_select(external_reference_select), .low_power(low_power));
